/* File: hdl/adcs_defs.vh */
// Constants for the converter sequencer and its result registers.
// Assumes inclusion by adcs_sequencer.v and by its checker and bench; definitions, no logic.
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADCS_OFF_RES_LOW    8'h00
`define ADCS_OFF_RES_HIGH   8'h04
`define ADCS_OFF_CTRL_FIRST 8'h08
`define ADCS_OFF_CTRL_SECND 8'h0C
`define ADCS_ADR_W          8

// ----------------------------------------------------------------
// First control register fields
// ----------------------------------------------------------------
`define ADCS_BIT_START      7
`define ADCS_BIT_BUSY       6
`define ADCS_BIT_ENABLE     5
`define ADCS_BIT_ALIGN      4
`define ADCS_CH_HI          3
`define ADCS_CH_LO          0

// ----------------------------------------------------------------
// Second control register fields
// ----------------------------------------------------------------
`define ADCS_SRC_HI         7
`define ADCS_SRC_LO         5
`define ADCS_REF_HI         4
`define ADCS_REF_LO         3
`define ADCS_DIV_HI         2
`define ADCS_DIV_LO         0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ADCS_RST_BYTE       8'h00
`define ADCS_RST_RES        12'h000
`define ADCS_SRC_AMP2       3'h1
`define ADCS_SRC_FILT       3'h2
`define ADCS_SRC_AMP1       3'h3
`define ADCS_SRC_BATT       3'h4
`define ADCS_CH_LAST        4'h3
`define ADCS_RES_W          12
`define ADCS_BIT_MSB        4'hB
`define ADCS_DIVCNT_W       7
`define ADCS_PIN_N          4

`endif

/* File: hdl/adcs_sequencer.v */
// Converter sequencer: control registers, source routing, SAR control, result pair.
// Assumes a classic Wishbone master on clk_i, an analog SAR array and comparator
// outside, and pin-share selections from logic on the same clock.
`timescale 1ns/10ps
`include "adcs_defs.vh"

// Behaviour
// [RULE1] Result is 12-bit unsigned over two bytes
// [RULE2] Exactly one of eight sources reaches converter; none here for a pin source with channel code above 3
// [RULE3] Channel field picks external pin
// [RULE4] Source field picks internal or external
// [RULE5] Left alignment: high D11..4, low D3..0
// [RULE6] Right alignment: high D11..8, low D7..0
// [RULE7] Unused result bits read zero
// [RULE8] Results unchanged while converter disabled
// [RULE9] Start on start bit high then low
// [RULE10] Busy set once conversion initiated
// [RULE11] Busy cleared when conversion finishes
// [RULE12] Converter powered off while enable low
// [RULE13] Converter pins lose general I/O functions
// [RULE14] Converter pins lose pull-high resistor
// [RULE15] Software sets pin sharing before channel
// [RULE16] Software parks channel when internal selected
// [RULE17] One converter, one source at once
// [RULE18] Source codes map pins and internal signals
// [RULE19] Channel codes 0..3 pins, rest float
// [RULE20] Divider code selects clock divided by 2^n
// [RULE21] Completion raises converter interrupt request
// [RULE22] Results and busy update on one edge
module adcs_sequencer
(
    // Clock, reset, enable
    input  wire                       clk_i,
    input  wire                       rst_i,
    input  wire                       ce_i,
    // Wishbone slave
    input  wire                       wb_cyc_i,
    input  wire                       wb_stb_i,
    input  wire                       wb_we_i,
    input  wire [`ADCS_ADR_W-1:0]     wb_adr_i,
    input  wire [3:0]                 wb_sel_i,
    input  wire [31:0]                wb_dat_i,
    output reg  [31:0]                wb_dat_o,
    output reg                        wb_ack_o,
    // Pin sharing
    input  wire [`ADCS_PIN_N-1:0]     pin_share_adc_i,
    output wire [`ADCS_PIN_N-1:0]     pin_func_off_o,
    output wire [`ADCS_PIN_N-1:0]     pullup_off_o,
    // Analog front end
    input  wire                       comp_i,
    output reg                        adc_power_o,
    output reg  [`ADCS_PIN_N-1:0]     ext_pin_sel_o,
    output reg  [3:0]                 int_src_sel_o,
    output reg  [1:0]                 ref_sel_o,
    output reg                        sample_o,
    output reg  [`ADCS_RES_W-1:0]     sar_code_o,
    // Completion
    output reg                        adc_irq_o
);

    // ----------------------------------------------------------------
    // State codes
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_SAMPLE = 3'b010;
    localparam [2:0] ST_CONV   = 3'b100;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg  [7:0]                 ctrl0_q;
    reg  [7:0]                 ctrl1_q;
    reg  [`ADCS_RES_W-1:0]     result_q;
    reg                        busy_q;
    reg  [2:0]                 state_q;
    reg  [`ADCS_DIVCNT_W-1:0]  div_cnt_q;
    reg  [3:0]                 bit_q;
    reg  [`ADCS_RES_W-1:0]     trial_q;
    reg                        comp_meta_q;
    reg                        comp_sync_q;
    reg  [7:0]                 rd_byte;
    reg  [7:0]                 wr_ctrl0;
    reg                        start_seen;
    wire                       req;
    wire                       wr_en;
    wire                       enable;
    wire                       tick;
    wire [`ADCS_DIVCNT_W-1:0]  div_top;
    wire                       align;
    wire                       ext_src;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Terminal count of divider for code n: 2^n - 1
    function [`ADCS_DIVCNT_W-1:0] div_limit;
        input [2:0] code;
        begin
            div_limit = ({`ADCS_DIVCNT_W{1'b1}} >> (3'h7 - code));
        end
    endfunction

    // Formats one result byte for the chosen alignment
    function [7:0] res_byte;
        input [`ADCS_RES_W-1:0] d;
        input                   right;
        input                   high;
        begin
            if (!right && high)
                res_byte = d[11:4];                      // see [RULE5]
            else if (!right)
                res_byte = {d[3:0], 4'h0};               // see [RULE5] see [RULE7]
            else if (high)
                res_byte = {4'h0, d[11:8]};              // see [RULE6] see [RULE7]
            else
                res_byte = d[7:0];                       // see [RULE6]
        end
    endfunction

    // Sets one bit of a code
    function [`ADCS_RES_W-1:0] with_bit;
        input [`ADCS_RES_W-1:0] code;
        input [3:0]             idx;
        begin
            with_bit = code | ({{(`ADCS_RES_W-1){1'b0}}, 1'b1} << idx);
        end
    endfunction

    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en   = req & wb_we_i & wb_sel_i[0];
    assign enable  = ctrl0_q[`ADCS_BIT_ENABLE];
    assign align   = ctrl0_q[`ADCS_BIT_ALIGN];
    assign div_top = div_limit(ctrl1_q[`ADCS_DIV_HI:`ADCS_DIV_LO]);
    assign tick    = (div_cnt_q == div_top);             // see [RULE20]

    // ----------------------------------------------------------------
    // Source routing
    // ----------------------------------------------------------------
    // Codes other than the four internal ones select the pins
    assign ext_src = (ctrl1_q[`ADCS_SRC_HI:`ADCS_SRC_LO] < `ADCS_SRC_AMP2) ||
                     (ctrl1_q[`ADCS_SRC_HI:`ADCS_SRC_LO] > `ADCS_SRC_BATT);  // see [RULE18]

    always @*
    begin
        ext_pin_sel_o = {`ADCS_PIN_N{1'b0}};
        int_src_sel_o = 4'h0;
        if (ext_src)
        begin
            // Pin is connected only for codes 0..3, otherwise floating
            if (ctrl0_q[`ADCS_CH_HI:`ADCS_CH_LO] <= `ADCS_CH_LAST)              // see [RULE19]
                ext_pin_sel_o[ctrl0_q[1:0]] = 1'b1;      // see [RULE3] see [RULE17]
        end
        else
        begin
            // Internal signal alone, pins held off
            case (ctrl1_q[`ADCS_SRC_HI:`ADCS_SRC_LO])    // see [RULE4] see [RULE2]
                `ADCS_SRC_AMP2: int_src_sel_o = 4'b0001;
                `ADCS_SRC_FILT: int_src_sel_o = 4'b0010;
                `ADCS_SRC_AMP1: int_src_sel_o = 4'b0100;
                `ADCS_SRC_BATT: int_src_sel_o = 4'b1000; // see [RULE18]
                default:        int_src_sel_o = 4'h0;
            endcase
        end
    end

    // Pins claimed by the converter drop other functions and pull-highs
    assign pin_func_off_o = pin_share_adc_i;             // see [RULE13]
    assign pullup_off_o   = pin_share_adc_i;             // see [RULE14]

    // ----------------------------------------------------------------
    // Start detection
    // ----------------------------------------------------------------
    always @*
    begin
        wr_ctrl0   = ctrl0_q;
        start_seen = 1'b0;
        if (wr_en && (wb_adr_i == `ADCS_OFF_CTRL_FIRST))
        begin
            wr_ctrl0 = wb_dat_i[7:0];
            // Start bit held high and now written low
            start_seen = ctrl0_q[`ADCS_BIT_START] &
                         ~wb_dat_i[`ADCS_BIT_START];     // see [RULE9]
        end
    end

    // ----------------------------------------------------------------
    // Comparator synchroniser
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            comp_meta_q <= 1'b0;
            comp_sync_q <= 1'b0;
        end
        else if (ce_i)
        begin
            comp_meta_q <= comp_i;
            comp_sync_q <= comp_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl0_q <= `ADCS_RST_BYTE;
            ctrl1_q <= `ADCS_RST_BYTE;
        end
        else if (ce_i)
        begin
            // Busy bit is never stored here
            ctrl0_q <= wr_ctrl0 & ~(8'h01 << `ADCS_BIT_BUSY);
            if (wr_en && (wb_adr_i == `ADCS_OFF_CTRL_SECND))
                ctrl1_q <= wb_dat_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q    <= ST_IDLE;
            busy_q     <= 1'b0;
            div_cnt_q  <= {`ADCS_DIVCNT_W{1'b0}};
            bit_q      <= `ADCS_BIT_MSB;
            trial_q    <= `ADCS_RST_RES;
            result_q   <= `ADCS_RST_RES;
            sample_o   <= 1'b0;
            sar_code_o <= `ADCS_RST_RES;
            adc_irq_o  <= 1'b0;
        end
        else if (ce_i)
        begin
            adc_irq_o <= 1'b0;
            div_cnt_q <= tick ? {`ADCS_DIVCNT_W{1'b0}} : div_cnt_q + 1'b1;
            case (state_q)
                ST_IDLE:
                begin
                    if (start_seen && enable)
                    begin
                        busy_q    <= 1'b1;               // see [RULE10]
                        state_q   <= ST_SAMPLE;
                        sample_o  <= 1'b1;
                        div_cnt_q <= {`ADCS_DIVCNT_W{1'b0}};
                    end
                end
                ST_SAMPLE:
                begin
                    if (!enable)
                    begin
                        busy_q   <= 1'b0;                // see [RULE8]
                        sample_o <= 1'b0;
                        state_q  <= ST_IDLE;
                    end
                    else if (tick)
                    begin
                        sample_o   <= 1'b0;
                        bit_q      <= `ADCS_BIT_MSB;
                        trial_q    <= `ADCS_RST_RES;
                        sar_code_o <= with_bit(`ADCS_RST_RES, `ADCS_BIT_MSB);
                        state_q    <= ST_CONV;
                    end
                end
                ST_CONV:
                begin
                    if (!enable)
                    begin
                        busy_q     <= 1'b0;              // see [RULE8]
                        sar_code_o <= `ADCS_RST_RES;
                        state_q    <= ST_IDLE;
                    end
                    else if (tick)
                    begin
                        if (bit_q == 4'h0)
                        begin
                            // Result pair and busy change together
                            result_q   <= comp_sync_q ? sar_code_o : trial_q; // see [RULE22]
                            busy_q     <= 1'b0;          // see [RULE11]
                            adc_irq_o  <= 1'b1;          // see [RULE21]
                            sar_code_o <= `ADCS_RST_RES;
                            state_q    <= ST_IDLE;
                        end
                        else
                        begin
                            // Keep bit when input is at or above trial
                            trial_q    <= comp_sync_q ? sar_code_o : trial_q; // see [RULE1]
                            sar_code_o <= with_bit(comp_sync_q ? sar_code_o : trial_q,
                                                   bit_q - 1'b1);
                            bit_q      <= bit_q - 1'b1;
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Analog controls
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            adc_power_o <= 1'b0;
            ref_sel_o   <= 2'h0;
        end
        else if (ce_i)
        begin
            adc_power_o <= enable;                       // see [RULE12]
            ref_sel_o   <= ctrl1_q[`ADCS_REF_HI:`ADCS_REF_LO];
        end
    end

    // ----------------------------------------------------------------
    // Wishbone read path
    // ----------------------------------------------------------------
    always @*
    begin
        rd_byte = 8'h00;
        case (wb_adr_i)
            `ADCS_OFF_RES_LOW:    rd_byte = res_byte(result_q, align, 1'b0);
            `ADCS_OFF_RES_HIGH:   rd_byte = res_byte(result_q, align, 1'b1);
            `ADCS_OFF_CTRL_FIRST: rd_byte = ctrl0_q | ({7'h00, busy_q} << `ADCS_BIT_BUSY);
            `ADCS_OFF_CTRL_SECND: rd_byte = ctrl1_q;
            default:              rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= req;
            if (req)
                wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

endmodule

/* File: hdl/README_unused.v */
`timescale 1ns/10ps

/* File: verification/adcs_checker.sv */
// Port checker for the converter sequencer.
// Assumes binding to adcs_sequencer; one clock, synchronous active-high reset.
`timescale 1ns/10ps
`include "adcs_defs.vh"
module adcs_checker
(
    // Clock, reset, enable
    input wire                   clk_i,
    input wire                   rst_i,
    input wire                   ce_i,
    // Wishbone
    input wire                   wb_cyc_i,
    input wire                   wb_stb_i,
    input wire                   wb_we_i,
    input wire [`ADCS_ADR_W-1:0] wb_adr_i,
    input wire [3:0]             wb_sel_i,
    input wire [31:0]            wb_dat_i,
    input wire                   wb_ack_o,
    // Pins and front end
    input wire [`ADCS_PIN_N-1:0] pin_share_adc_i,
    input wire [`ADCS_PIN_N-1:0] pin_func_off_o,
    input wire [`ADCS_PIN_N-1:0] pullup_off_o,
    input wire                   adc_power_o,
    input wire [`ADCS_PIN_N-1:0] ext_pin_sel_o,
    input wire [3:0]             int_src_sel_o,
    input wire                   sample_o,
    input wire [`ADCS_RES_W-1:0] sar_code_o,
    input wire [1:0]             ref_sel_o,
    input wire                   adc_irq_o
);
    reg  [3:0]  ch_q;
    reg  [2:0]  src_q;
    reg  [2:0]  div_q;
    reg  [11:0] cnt_q;
    wire        take    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
    wire        wr_any  = take & wb_we_i & wb_sel_i[0];
    wire        wr_1st  = wr_any & (wb_adr_i == `ADCS_OFF_CTRL_FIRST);
    wire        wr_2nd  = wr_any & (wb_adr_i == `ADCS_OFF_CTRL_SECND);
    wire        ext_src = (src_q == 3'h0) | (src_q > 3'h4);
    wire [3:0]  exp_ext = (ext_src & (ch_q < 4'h4)) ? (4'h1 << ch_q[1:0]) : 4'h0;
    wire [3:0]  exp_int = ext_src ? 4'h0 : (4'h1 << (src_q - 3'h1));

    // ----------------------------------------------------------------
    // Shadow of routing fields and conversion cycle count
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ch_q  <= 4'h0;
            src_q <= 3'h0;
            div_q <= 3'h0;
        end
        else
        begin
            if (wr_1st)
                ch_q <= wb_dat_i[3:0];
            if (wr_2nd)
            begin
                src_q <= wb_dat_i[7:5];
                div_q <= wb_dat_i[2:0];
            end
        end
    end

    always @(posedge clk_i)
    begin
        if ($rose(sample_o))
            cnt_q <= 12'h001;
        else if (ce_i)
            cnt_q <= cnt_q + 12'h001;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take;
        take;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_end_pulse;
        (adc_irq_o && !sample_o) ##1 !adc_irq_o;
    endsequence

    AST_ACK: assert property (s_take |=> s_ack_pulse)
        else $error("ack not a one-cycle answer");
    AST_PIN_FUNC: assert property (pin_func_off_o == pin_share_adc_i)
        else $error("pin functions not removed");
    AST_PULLUP: assert property (pullup_off_o == pin_share_adc_i)
        else $error("pull-high not removed");
    AST_ONE_SRC: assert property ($onehot0({ext_pin_sel_o, int_src_sel_o}))
        else $error("more than one source routed");
    AST_EXT_ROUTE: assert property (ext_pin_sel_o == exp_ext)
        else $error("external pin routing wrong");
    AST_INT_ROUTE: assert property (int_src_sel_o == exp_int)
        else $error("internal source routing wrong");
    AST_POWER: assert property (wr_1st |-> ##2 adc_power_o == $past(wb_dat_i[5], 2))
        else $error("power does not follow enable");
    AST_REF_SEL: assert property (wr_2nd |-> ##2 ref_sel_o == $past(wb_dat_i[4:3], 2))
        else $error("reference select does not follow field");
    AST_SAMPLE_PWR: assert property (sample_o |-> adc_power_o)
        else $error("sampling while powered off");
    AST_START_CAUSE: assert property ($rose(sample_o) |-> $past(wr_1st && !wb_dat_i[7]))
        else $error("conversion began without start sequence");
    AST_FIRST_TRIAL: assert property ($fell(sample_o) && adc_power_o |-> sar_code_o == 12'h800)
        else $error("first trial code not MSB");
    AST_CONV_TIME: assert property (adc_irq_o |-> cnt_q == (12'h00D << div_q))
        else $error("conversion length wrong");
    AST_END_PULSE: assert property (adc_irq_o |-> s_end_pulse)
        else $error("end pulse malformed");
endmodule

bind adcs_sequencer adcs_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .pin_share_adc_i(pin_share_adc_i), .pin_func_off_o(pin_func_off_o),
    .pullup_off_o(pullup_off_o), .adc_power_o(adc_power_o), .ext_pin_sel_o(ext_pin_sel_o),
    .int_src_sel_o(int_src_sel_o), .sample_o(sample_o), .sar_code_o(sar_code_o),
    .ref_sel_o(ref_sel_o), .adc_irq_o(adc_irq_o));

/* File: verification/adcs_sequencer_tb.sv */
// Self-checking bench for the converter sequencer.
// Assumes adcs_sequencer and adcs_checker compiled before it.
`timescale 1ns/10ps
`include "adcs_defs.vh"
module adcs_sequencer_tb;
    reg          clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, comp_i;
    reg  [7:0]   wb_adr_i;
    reg  [3:0]   wb_sel_i, pin_share_adc_i;
    reg  [31:0]  wb_dat_i;
    wire [31:0]  wb_dat_o;
    wire         wb_ack_o, adc_power_o, sample_o, adc_irq_o;
    wire [3:0]   pin_func_off_o, pullup_off_o, ext_pin_sel_o, int_src_sel_o;
    wire [1:0]   ref_sel_o;
    wire [11:0]  sar_code_o;
    integer      bad_count, n_tests, seed, i, j;
    reg  [11:0]  target, res;
    reg  [7:0]   base;
    logic [31:0] exp_q[$];

    adcs_sequencer uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_share_adc_i(pin_share_adc_i),
        .pin_func_off_o(pin_func_off_o), .pullup_off_o(pullup_off_o), .comp_i(comp_i),
        .adc_power_o(adc_power_o), .ext_pin_sel_o(ext_pin_sel_o), .int_src_sel_o(int_src_sel_o),
        .ref_sel_o(ref_sel_o), .sample_o(sample_o), .sar_code_o(sar_code_o), .adc_irq_o(adc_irq_o));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // Comparator stand-in, pin sharing, read monitor
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        comp_i <= ((target >= sar_code_o) === 1'b1);
        pin_share_adc_i <= 4'($random(seed)) | 4'h1;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            cmp(exp_q.pop_front(), wb_dat_o);
    end

    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    begin
        n_tests = n_tests + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    end
    endtask

    task final_report;
    begin
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask

    task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [7:0] d,
                            input logic [3:0] s);
        integer k;
    begin
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k = k + 1;
        end
        while (wb_ack_o !== 1'b1 && k < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (k >= 50)
        begin
            bad_count = bad_count + 1;
            final_report;
        end
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb_cycle(a, 1'b1, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
    begin
        exp_q.push_back({24'h0, e});
        wb_cycle(a, 1'b0, 8'h00, 4'h1);
    end
    endtask

    task automatic check_res(input logic [11:0] v, input logic al);
    begin
        if (al)
        begin
            rd(`ADCS_OFF_RES_HIGH, {4'h0, v[11:8]});
            rd(`ADCS_OFF_RES_LOW, v[7:0]);
        end
        else
        begin
            rd(`ADCS_OFF_RES_HIGH, v[11:4]);
            rd(`ADCS_OFF_RES_LOW, {v[3:0], 4'h0});
        end
    end
    endtask

    task automatic wait_irq;
        integer k;
    begin
        k = 0;
        while (adc_irq_o !== 1'b1 && k < 3000)
        begin
            @(posedge clk_i);
            k = k + 1;
        end
        if (k >= 3000)
        begin
            bad_count = bad_count + 1;
            final_report;
        end
    end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 15;
        bad_count = 0;
        n_tests = 0;
        target = 12'h000;
        rst_i = 1'b1;
        ce_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 5; i = i + 1)
            rd(8'(i * 4), 8'h00);
        wr(8'h10, 8'hFF);
        wb_cycle(`ADCS_OFF_CTRL_SECND, 1'b1, 8'hFF, 4'h0);
        rd(`ADCS_OFF_CTRL_SECND, 8'h00);
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(`ADCS_OFF_CTRL_SECND, {i[2:0], 5'h00});
            for (j = 0; j < 16; j = j + 1)
            begin
                wr(`ADCS_OFF_CTRL_FIRST, {4'h0, j[3:0]});
                rd(`ADCS_OFF_CTRL_FIRST, {4'h0, j[3:0]});
            end
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            target = 12'($random(seed));
            base = {3'b001, i[0], 4'h0};
            wr(`ADCS_OFF_CTRL_SECND, {3'h0, i[1:0], i[2:0]});
            wr(`ADCS_OFF_CTRL_FIRST, base);
            wr(`ADCS_OFF_CTRL_FIRST, base | 8'h80);
            wr(`ADCS_OFF_CTRL_FIRST, base);
            rd(`ADCS_OFF_CTRL_FIRST, base | 8'h40);
            if (i == 4)
            begin
                // Freeze mid-conversion, result must still come out right
                ce_i <= 1'b0;
                repeat (10) @(posedge clk_i);
                ce_i <= 1'b1;
            end
            wait_irq;
            rd(`ADCS_OFF_CTRL_FIRST, base);
            if (i >= 2)
            begin
                check_res(target, i[0]);
                wr(`ADCS_OFF_CTRL_FIRST, base ^ 8'h10);
                check_res(target, ~i[0]);
            end
        end
        res = target;
        target = ~res;
        wr(`ADCS_OFF_CTRL_FIRST, 8'h00);
        wr(`ADCS_OFF_CTRL_FIRST, 8'h80);
        wr(`ADCS_OFF_CTRL_FIRST, 8'h00);
        rd(`ADCS_OFF_CTRL_FIRST, 8'h00);
        wr(`ADCS_OFF_CTRL_FIRST, 8'h20);
        wr(`ADCS_OFF_CTRL_FIRST, 8'h20);
        rd(`ADCS_OFF_CTRL_FIRST, 8'h20);
        wr(`ADCS_OFF_CTRL_SECND, 8'h23);
        wr(`ADCS_OFF_CTRL_FIRST, 8'hAF);
        wr(`ADCS_OFF_CTRL_FIRST, 8'h2F);
        repeat (30) @(posedge clk_i);
        wr(`ADCS_OFF_CTRL_FIRST, 8'h0F);
        rd(`ADCS_OFF_CTRL_FIRST, 8'h0F);
        repeat (120) @(posedge clk_i);
        check_res(res, 1'b0);
        repeat (3) @(posedge clk_i);
        final_report;
    end
endmodule
